// *** rtl/mcs_pkg.sv ***
// Shared constants for the multiphase commutation sequencer
package mcs_pkg;
  // ------------------------------------------------------------
  // Widths and table sizes
  // ------------------------------------------------------------
  localparam int CH_N      = 8;   // master plus up to seven slaves
  localparam int ST_W      = 8;   // state number width
  localparam int LEN_W     = 8;   // state length width
  localparam int POS_W     = 16;  // position, offset and limits
  localparam int TBL_N     = 22;  // largest table
  localparam int TBL_AW    = 5;
  localparam int CHN_W     = 4;
  // ------------------------------------------------------------
  // Table limits per master channel
  // ------------------------------------------------------------
  localparam logic [ST_W-1:0]  MAX_ST_STD = 8'h06;
  localparam logic [ST_W-1:0]  MAX_ST_13  = 8'h16;
  localparam logic [ST_W-1:0]  MAX_ST_14  = 8'h0e;
  localparam logic [CHN_W-1:0] MASTER_13  = 4'hd;
  localparam logic [CHN_W-1:0] MASTER_14  = 4'he;
  // ------------------------------------------------------------
  // Host service codes and timing
  // ------------------------------------------------------------
  localparam logic [1:0]       FORCE_CODE = 2'h2;
  localparam logic [POS_W-1:0] MATCH_LEAD = 16'h0002;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [ST_W-1:0]  STATE_RST  = 8'h00;
  localparam logic [CH_N-1:0]  PINS_RST   = 8'h00;
  localparam logic [POS_W-1:0] LIMIT_RST  = 16'h0000;
endpackage

// *** rtl/mcs_match_if.sv ***
// Carrier between the sequencer core and its match output stage
`timescale 1ns/1ns
`default_nettype none
interface mcs_match_if;
  logic                          arm;
  logic [mcs_pkg::CH_N-1:0]      pattern;
  logic [mcs_pkg::POS_W-1:0]     when_tb;
  logic [mcs_pkg::CH_N-1:0]      pins;
  logic                          busy;
  modport seq (output arm, pattern, when_tb, input pins, busy);
  modport out (input arm, pattern, when_tb, output pins, busy);
endinterface
`default_nettype wire

// *** rtl/mcs_match_unit.sv ***
// Output match stage: all pins switch together on a timebase match
`timescale 1ns/1ns
`default_nettype none
module mcs_match_unit (
  // Clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      rst_in,
  // Timebase
  input  wire logic [mcs_pkg::POS_W-1:0] tb_in,
  // Sequencer side
  mcs_match_if.out                       mif
);
  logic                      pend_q;
  logic [mcs_pkg::CH_N-1:0]  pat_q;
  logic [mcs_pkg::POS_W-1:0] when_q;
  logic [mcs_pkg::CH_N-1:0]  pins_q;
  wire                       hit = pend_q && (tb_in == when_q);

  // Capture a new pattern; a fresh arm replaces one still pending
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pend_q <= 1'b0;
      pat_q  <= mcs_pkg::PINS_RST;
      when_q <= mcs_pkg::LIMIT_RST;
    end else if (mif.arm) begin
      pend_q <= 1'b1;
      pat_q  <= mif.pattern;
      when_q <= mif.when_tb;
    end else if (hit) begin
      pend_q <= 1'b0;
    end
  end

  // Every pin changes on the same match edge
  always_ff @(posedge clock_in) begin
    if (rst_in) pins_q <= mcs_pkg::PINS_RST;
    else if (hit && !mif.arm) pins_q <= pat_q;
  end

  assign mif.pins = pins_q;
  assign mif.busy = pend_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  match_apply_a: assert property (@(posedge clock_in) disable iff (rst_in)
    hit && !mif.arm |=> pins_q == $past(pat_q))
    else $error("pins not applied on match");
  match_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !hit |=> $stable(pins_q))
    else $error("pins changed without match");
endmodule
`default_nettype wire

// *** rtl/mcs_sequencer.sv ***
// Multiphase commutation sequencer core, master channel service
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Drives outputs on up to eight adjacent channels, master plus slaves.
// - All servicing runs in the master; slaves only mirror its outputs.
// - New pin levels are applied together on a timebase output match.
// - Host sequence bits pick sensored or sensorless operation.
// - Sensored link fetches that state's pins from the table and outputs them.
// - Sensorless reads the position counter from a programmable address.
// - Keeps upper and lower limits; compares adjusted position each service.
// - Passing a limit steps state, loads entry length and pins, outputs pins.
// - CPU offset is added to position before the limit tests.
// - State count, lengths, channel count and patterns are all programmable.
// - Table size: six states, twenty-two for master 13, fourteen for 14.
// - Each state length is an unsigned 8-bit position count.
// - Adjacent entries with equal pins act as one longer state.
// - Match sub-mode: a periodic match triggers each evaluation.
// - Link sub-mode: a link request triggers each evaluation.
// - CPU may force any state in any cycle but one in which a limit crossing steps the state.
// - CPU may read the current state number without disturbance.
// - Force: write state number, then host request code 2 drives its pattern.
module mcs_sequencer (
  // Clock and reset
  input  wire logic                         clock_in,
  input  wire logic                         rst_in,
  // Mode and configuration
  input  wire logic                         sensorless_in,
  input  wire logic                         link_update_in,
  input  wire logic [mcs_pkg::CHN_W-1:0]    master_channel_in,
  input  wire logic [mcs_pkg::CHN_W-1:0]    output_channel_count_in,
  input  wire logic [mcs_pkg::ST_W-1:0]     state_count_in,
  input  wire logic [mcs_pkg::POS_W-1:0]    offset_in,
  input  wire logic [mcs_pkg::POS_W-1:0]    update_period_in,
  input  wire logic [mcs_pkg::ST_W-1:0]     counter_addr_in,
  // State table write port
  input  wire logic                         tbl_we_in,
  input  wire logic [mcs_pkg::TBL_AW-1:0]   tbl_idx_in,
  input  wire logic [mcs_pkg::LEN_W-1:0]    tbl_len_in,
  input  wire logic [mcs_pkg::CH_N-1:0]     tbl_pins_in,
  // State number write, CPU or hall_state_decoder
  input  wire logic                         state_we_in,
  input  wire logic [mcs_pkg::ST_W-1:0]     state_wdata_in,
  // Link request and host_service_request
  input  wire logic                         link_in,
  input  wire logic                         host_service_request_in,
  input  wire logic [1:0]                   host_service_code_in,
  // Position counter read
  output logic      [mcs_pkg::ST_W-1:0]     pos_addr_out,
  input  wire logic [mcs_pkg::POS_W-1:0]    pos_data_in,
  // Status and outputs
  output logic      [mcs_pkg::ST_W-1:0]     state_no_out,
  output logic      [mcs_pkg::POS_W-1:0]    timebase_out,
  output logic      [mcs_pkg::CH_N-1:0]     drive_out,
  output logic      [mcs_pkg::CH_N-1:0]     drive_en_out,
  output logic                              busy_out
);

  // ------------------------------------------------------------
  // Types and storage
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    MCS_IDLE  = 4'h1,
    MCS_FETCH = 4'h2,
    MCS_EVAL  = 4'h4,
    MCS_OUT   = 4'h8
  } mcs_state_t;

  mcs_state_t                  fsm_q;
  mcs_state_t                  fsm_d;
  logic [mcs_pkg::LEN_W-1:0]   tbl_len [mcs_pkg::TBL_N];
  logic [mcs_pkg::CH_N-1:0]    tbl_pin [mcs_pkg::TBL_N];
  logic [mcs_pkg::ST_W-1:0]    state_q;
  logic [mcs_pkg::POS_W-1:0]   upper_q;
  logic [mcs_pkg::POS_W-1:0]   lower_q;
  logic [mcs_pkg::POS_W-1:0]   tb_q;
  logic [mcs_pkg::POS_W-1:0]   per_q;
  logic                        svc_pend_q;
  logic                        force_pend_q;
  logic                        started_q;
  logic [mcs_pkg::CH_N-1:0]    cur_pins_q;

  mcs_match_if mif ();

  // ------------------------------------------------------------
  // Table size and state wrap
  // ------------------------------------------------------------
  // Master channel selects how many entries exist
  wire [mcs_pkg::ST_W-1:0] max_st =
    (master_channel_in == mcs_pkg::MASTER_13) ? mcs_pkg::MAX_ST_13 :
    (master_channel_in == mcs_pkg::MASTER_14) ? mcs_pkg::MAX_ST_14 :
    mcs_pkg::MAX_ST_STD;
  // Programmed count, clipped to the table and kept above zero
  wire [mcs_pkg::ST_W-1:0] n_st_raw =
    (state_count_in > max_st) ? max_st : state_count_in;
  wire [mcs_pkg::ST_W-1:0] n_st =
    (n_st_raw == 8'h00) ? 8'h01 : n_st_raw;
  wire [mcs_pkg::ST_W-1:0] last_st = n_st - 8'h01;
  // Circular neighbours of the current state
  wire [mcs_pkg::ST_W-1:0] st_up =
    (state_q >= last_st) ? 8'h00 : state_q + 8'h01;
  wire [mcs_pkg::ST_W-1:0] st_dn =
    (state_q == 8'h00 || state_q > last_st) ? last_st
    : state_q - 8'h01;
  // Table read indices, clipped to the array
  wire [mcs_pkg::TBL_AW-1:0] cur_idx =
    (state_q < mcs_pkg::MAX_ST_13) ? state_q[mcs_pkg::TBL_AW-1:0] : 5'h00;
  wire [mcs_pkg::TBL_AW-1:0] up_idx = st_up[mcs_pkg::TBL_AW-1:0];
  wire [mcs_pkg::TBL_AW-1:0] dn_idx = st_dn[mcs_pkg::TBL_AW-1:0];

  // ------------------------------------------------------------
  // Sensorless limit tests
  // ------------------------------------------------------------
  // Offset is added before the tests
  wire [mcs_pkg::POS_W-1:0] adj_pos = pos_data_in + offset_in;
  wire [mcs_pkg::POS_W-1:0] d_up    = adj_pos - upper_q;
  wire [mcs_pkg::POS_W-1:0] d_lo    = adj_pos - lower_q;
  // Signed differences tolerate counter wrap
  wire pass_up = started_q && !d_up[mcs_pkg::POS_W-1]
                 && (d_up != 16'h0000);
  wire pass_lo = started_q && d_lo[mcs_pkg::POS_W-1];
  wire [mcs_pkg::POS_W-1:0] len_up = {8'h00, tbl_len[up_idx]};
  wire [mcs_pkg::POS_W-1:0] len_dn = {8'h00, tbl_len[dn_idx]};
  wire [mcs_pkg::POS_W-1:0] len_cur = {8'h00, tbl_len[cur_idx]};

  // ------------------------------------------------------------
  // Service triggers
  // ------------------------------------------------------------
  wire per_mode  = sensorless_in && !link_update_in;
  wire per_fire  = per_mode && (per_q == 16'h0000);
  wire link_take = link_in && (!sensorless_in || link_update_in);
  wire force_go  = host_service_request_in
                   && (host_service_code_in == mcs_pkg::FORCE_CODE);
  wire in_idle   = (fsm_q == MCS_IDLE);
  wire take_frc  = in_idle && force_pend_q;
  wire take_svc  = in_idle && !force_pend_q && svc_pend_q;

  // ------------------------------------------------------------
  // Next state of the service sequence
  // ------------------------------------------------------------
  always_comb begin
    fsm_d = fsm_q;
    case (fsm_q)
      MCS_IDLE: begin
        if (take_frc) fsm_d = MCS_OUT;
        else if (take_svc && sensorless_in) fsm_d = MCS_FETCH;
        else if (take_svc) fsm_d = MCS_OUT;
      end
      MCS_FETCH: fsm_d = MCS_EVAL;
      MCS_EVAL: begin
        if (pass_up || pass_lo || !started_q) fsm_d = MCS_OUT;
        else fsm_d = MCS_IDLE;
      end
      MCS_OUT:   fsm_d = MCS_IDLE;
      default:   fsm_d = MCS_IDLE;
    endcase
  end

  // Service sequence register
  always_ff @(posedge clock_in) begin
    if (rst_in) fsm_q <= MCS_IDLE;
    else fsm_q <= fsm_d;
  end

  // ------------------------------------------------------------
  // Timebase and periodic match
  // ------------------------------------------------------------
  // Free running primary_timebase_counter
  always_ff @(posedge clock_in) begin
    if (rst_in) tb_q <= mcs_pkg::LIMIT_RST;
    else tb_q <= tb_q + 16'h0001;
  end

  // Periodic match reloads with the programmed period
  always_ff @(posedge clock_in) begin
    if (rst_in || !per_mode || per_fire) per_q <= update_period_in;
    else per_q <= per_q - 16'h0001;
  end

  // ------------------------------------------------------------
  // Pending requests; a new trigger wins over the take
  // ------------------------------------------------------------
  // Service request, held until the sequence is idle
  always_ff @(posedge clock_in) begin
    if (rst_in) svc_pend_q <= 1'b0;
    else if (per_fire || link_take) svc_pend_q <= 1'b1;
    else if (take_svc) svc_pend_q <= 1'b0;
  end

  // Force request; other service codes are ignored
  always_ff @(posedge clock_in) begin
    if (rst_in) force_pend_q <= 1'b0;
    else if (force_go) force_pend_q <= 1'b1;
    else if (take_frc) force_pend_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // State table storage
  // ------------------------------------------------------------
  // Not reset: every used entry must be written before the first service
  always_ff @(posedge clock_in) begin
    if (tbl_we_in && tbl_idx_in < mcs_pkg::TBL_AW'(mcs_pkg::TBL_N)) begin
      tbl_len[tbl_idx_in] <= tbl_len_in;
      tbl_pin[tbl_idx_in] <= tbl_pins_in;
    end
  end

  // ------------------------------------------------------------
  // State number; sequencer stepping wins over an outside write
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) state_q <= mcs_pkg::STATE_RST;
    else if (fsm_q == MCS_EVAL && started_q && pass_up) state_q <= st_up;
    else if (fsm_q == MCS_EVAL && started_q && pass_lo) state_q <= st_dn;
    else if (state_we_in) state_q <= state_wdata_in;
  end

  // ------------------------------------------------------------
  // Limits of the current state
  // ------------------------------------------------------------
  // First service, or the first service after a force, seats the window at the position
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      upper_q   <= mcs_pkg::LIMIT_RST;
      lower_q   <= mcs_pkg::LIMIT_RST;
      started_q <= 1'b0;
    end else if (take_frc || !sensorless_in) begin
      started_q <= 1'b0;
    end else if (fsm_q == MCS_EVAL && !started_q) begin
      lower_q   <= adj_pos;
      upper_q   <= adj_pos + len_cur;
      started_q <= 1'b1;
    end else if (fsm_q == MCS_EVAL && pass_up) begin
      lower_q   <= upper_q;
      upper_q   <= upper_q + len_up;
    end else if (fsm_q == MCS_EVAL && pass_lo) begin
      upper_q   <= lower_q;
      lower_q   <= lower_q - len_dn;
    end
  end

  // ------------------------------------------------------------
  // Output arming and channel enables
  // ------------------------------------------------------------
  // Equal patterns rearm to the same levels, so pins do not move
  assign mif.arm     = (fsm_q == MCS_OUT);
  assign mif.pattern = tbl_pin[cur_idx];
  assign mif.when_tb = tb_q + mcs_pkg::MATCH_LEAD;

  // One match stage switches all channels together
  mcs_match_unit u_match (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .tb_in    (tb_q),
    .mif      (mif)
  );

  // Pattern last armed, for the checks
  always_ff @(posedge clock_in) begin
    if (rst_in) cur_pins_q <= mcs_pkg::PINS_RST;
    else if (mif.arm) cur_pins_q <= mif.pattern;
  end

  // Channel index width for the enable compare
  localparam int CHN_N_W = mcs_pkg::CHN_W;

  // Channels beyond the programmed count stay low and undriven
  genvar gi;
  generate
    for (gi = 0; gi < mcs_pkg::CH_N; gi++) begin : g_ch
      wire used = (output_channel_count_in > CHN_N_W'(gi));
      assign drive_en_out[gi] = used;
      assign drive_out[gi]    = used & mif.pins[gi];
    end
  endgenerate

  // Read back for the CPU, with no side effect
  assign state_no_out = state_q;
  assign pos_addr_out = counter_addr_in;
  assign timebase_out = tb_q;
  assign busy_out     = !in_idle || mif.busy;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  mode_select_a: assert property (
    take_svc && sensorless_in |=> fsm_q == MCS_FETCH)
    else $error("sensorless service did not fetch position");
  sensored_out_a: assert property (
    take_svc && !sensorless_in |=> fsm_q == MCS_OUT ##1 cur_pins_q == $past(mif.pattern))
    else $error("sensored link did not output pattern");
  eval_after_fetch_a: assert property (
    fsm_q == MCS_FETCH |=> fsm_q == MCS_EVAL)
    else $error("evaluation did not follow fetch");
  step_up_a: assert property (
    fsm_q == MCS_EVAL && started_q && pass_up |=> state_q == $past(st_up) && mif.arm)
    else $error("upper crossing did not step state");
  step_dn_a: assert property (
    fsm_q == MCS_EVAL && started_q && !pass_up && pass_lo |=> state_q == $past(st_dn))
    else $error("lower crossing did not step state");
  wrap_range_a: assert property (
    fsm_q == MCS_EVAL && started_q && (pass_up || pass_lo) |=> state_q <= last_st)
    else $error("state left the table");
  table_limit_a: assert property (
    n_st >= 8'h01 && n_st <= max_st)
    else $error("state count exceeds table");
  period_fire_a: assert property (
    per_fire && in_idle && !force_pend_q |=> svc_pend_q ##1 fsm_q == MCS_FETCH)
    else $error("periodic match did not start service");
  force_out_a: assert property (
    force_go && in_idle && !force_pend_q |=> ##[1:4] mif.arm)
    else $error("force did not arm output");

  // Request capture, window seating and the quiet path
  link_take_a: assert property (
    link_take |=> svc_pend_q)
    else $error("link request was not taken");
  seat_window_a: assert property (
    fsm_q == MCS_EVAL && !started_q && sensorless_in
    |=> started_q && lower_q == $past(adj_pos) && upper_q - lower_q == $past(len_cur))
    else $error("first service did not seat the window");
  no_cross_a: assert property (
    fsm_q == MCS_EVAL && started_q && !pass_up && !pass_lo |=> in_idle && !mif.arm)
    else $error("output armed without a crossing");
  force_seat_a: assert property (
    take_frc |=> fsm_q == MCS_OUT && !started_q)
    else $error("force did not clear the window");
  period_reload_a: assert property (
    per_fire |=> per_q == $past(update_period_in))
    else $error("periodic match did not reload");
  state_write_a: assert property (
    state_we_in && fsm_q != MCS_EVAL |=> state_q == $past(state_wdata_in))
    else $error("state number write was lost");

  force_cov_c:  cover property (take_frc ##1 mif.arm);
  up_cov_c:     cover property (fsm_q == MCS_EVAL && started_q && pass_up);
  dn_cov_c:     cover property (fsm_q == MCS_EVAL && started_q && pass_lo);
  hall_cov_c:   cover property (take_svc && !sensorless_in);
  seat_cov_c:   cover property (fsm_q == MCS_EVAL && !started_q);
endmodule
`default_nettype wire

// *** dv/mcs_far_model.sv ***
// Far-side model: hall state decoder and position counter source
`timescale 1ns/1ns
`default_nettype none
module mcs_far_model #(
  parameter logic [7:0] POS_ADDR = 8'h42
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // Commands from the bench
  input  wire logic        hall_go_in,
  input  wire logic [7:0]  hall_state_in,
  input  wire logic [15:0] pos_in,
  // Sequencer side
  input  wire logic [7:0]  addr_in,
  output logic             state_we_out,
  output logic [7:0]       state_wdata_out,
  output logic             link_out,
  output logic [15:0]      pos_data_out
);
  // ----------------------------------------------------------
  // Hall decoder: state number first, link one cycle later
  // ----------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_we_out <= 1'b0;
      link_out     <= 1'b0;
    end else begin
      state_we_out <= hall_go_in;
      link_out     <= state_we_out;
    end
  end
  // Written state number, stale data inverted once the write is over
  always_ff @(posedge clock_in) begin
    state_wdata_out <= hall_go_in ? hall_state_in : ~state_wdata_out;
  end
  // ----------------------------------------------------------
  // Position source: a wrong address reads back inverted data
  // ----------------------------------------------------------
  assign pos_data_out = (addr_in == POS_ADDR) ? pos_in : ~pos_in;
endmodule
`default_nettype wire

// *** dv/multiphase_commutation_sequencer_test.sv ***
// Self-checking testbench for the commutation sequencer
`timescale 1ns/1ns
`default_nettype none
module multiphase_commutation_sequencer_test;
  // ----------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------
  logic clock_in, rst_in, sless, lupd, tbl_we, cpu_we, tb_link, svc_req, hall_go;
  logic far_we, far_link, busy, tbl_sel;
  logic [3:0] master, nch;
  logic [4:0] tbl_idx;
  logic [1:0] code;
  logic [7:0] scnt, caddr, tlen, tpins, cpu_data, far_data, hall_st, paddr, st_no, drv, drv_en;
  logic [15:0] offs, period, pos, pdata, tb;
  logic [7:0] pat [8];
  int fails, num_checks;
  wire [7:0] wdata = cpu_we ? cpu_data : far_data;
  // Device under test and far side
  mcs_sequencer dut (.clock_in(clock_in), .rst_in(rst_in), .sensorless_in(sless),
    .link_update_in(lupd), .master_channel_in(master), .output_channel_count_in(nch),
    .state_count_in(scnt), .offset_in(offs), .update_period_in(period),
    .counter_addr_in(caddr), .tbl_we_in(tbl_we), .tbl_idx_in(tbl_idx), .tbl_len_in(tlen),
    .tbl_pins_in(tpins), .state_we_in(cpu_we | far_we), .state_wdata_in(wdata),
    .link_in(far_link | tb_link), .host_service_request_in(svc_req),
    .host_service_code_in(code),
    .pos_addr_out(paddr), .pos_data_in(pdata), .state_no_out(st_no), .timebase_out(tb),
    .drive_out(drv), .drive_en_out(drv_en), .busy_out(busy));
  mcs_far_model far (.clock_in(clock_in), .rst_in(rst_in), .hall_go_in(hall_go),
    .hall_state_in(hall_st), .pos_in(pos), .addr_in(paddr), .state_we_out(far_we),
    .state_wdata_out(far_data), .link_out(far_link), .pos_data_out(pdata));
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Wait for the sequence and any pending match to finish
  task automatic idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 40) begin
      tick(1);
      i++;
    end
    if (i == 40) check("busy_out", {15'h0000, busy}, 16'h0000);
    tick(1);
  endtask
  // Expected pins: pattern masked to the channels in use
  function automatic logic [15:0] pins(input logic [7:0] p, input logic [3:0] n);
    logic [8:0] m;
    m = (9'h001 << n) - 9'h001;
    return {8'h00, p & m[7:0]};
  endfunction
  task automatic hall(input logic [7:0] s);
    hall_go <= 1'b1;
    hall_st <= s;
    tick(1);
    hall_go <= 1'b0;
    tick(6);
    idle();
  endtask
  task automatic force_st(input logic [7:0] s, input logic [1:0] c);
    cpu_we   <= 1'b1;
    cpu_data <= s;
    tick(1);
    cpu_we  <= 1'b0;
    svc_req <= 1'b1;
    code    <= c;
    tick(1);
    svc_req <= 1'b0;
    tick(5);
    idle();
  endtask
  task automatic await_st(input logic [7:0] exp);
    int i;
    i = 0;
    while (st_no !== exp && i < 60) begin
      tick(1);
      i++;
    end
    check("state_no_out", {8'h00, st_no}, {8'h00, exp});
    tick(2);
    idle();
    check("drive_out", {8'h00, drv}, pins(pat[exp], nch));
  endtask
  // One-cycle link request from another channel
  task automatic link_pulse();
    tb_link <= 1'b1;
    tick(1);
    tb_link <= 1'b0;
  endtask
  // Watchdog on a hung sequence
  initial begin
    tick(20000);
    fails++;
    summarize();
  end
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    logic [15:0] t0;
    pat = '{8'h81, 8'h42, 8'h24, 8'h18, 8'h3c, 8'hc3, 8'h0f, 8'hf0};
    rst_in   <= 1'b1;
    sless    <= 1'b0;
    lupd     <= 1'b0;
    tbl_we   <= 1'b0;
    cpu_we   <= 1'b0;
    tb_link  <= 1'b0;
    svc_req  <= 1'b0;
    hall_go  <= 1'b0;
    master   <= 4'h0;
    nch      <= 4'h8;
    tbl_idx  <= 5'h00;
    code     <= 2'h0;
    scnt     <= 8'h08;
    caddr    <= 8'h42;
    tlen     <= 8'h00;
    tpins    <= 8'h00;
    cpu_data <= 8'h00;
    hall_st  <= 8'h00;
    offs     <= 16'h0000;
    period   <= 16'h000f;
    pos      <= 16'h0000;
    tick(20);
    rst_in <= 1'b0;
    tick(2);
    check("drive_out", {8'h00, drv}, 16'h0000);
    check("state_no_out", {8'h00, st_no}, 16'h0000);
    check("drive_en_out", {8'h00, drv_en}, 16'h00ff);
    check("pos_addr_out", {8'h00, paddr}, 16'h0042);
    t0 = tb;
    tick(3);
    check("timebase_out", tb, t0 + 16'h0003);
    // Table load, equal lengths of ten position counts
    for (int i = 0; i < 8; i++) begin
      tbl_we  <= 1'b1;
      tbl_idx <= i[4:0];
      tlen    <= 8'h0a;
      tpins   <= pat[i];
      tick(1);
    end
    tbl_we <= 1'b0;
    tick(1);
    // Sensored: every state through the hall decoder
    for (int s = 0; s < 6; s++) begin
      hall(s[7:0]);
      check("drive_out", {8'h00, drv}, pins(pat[s], nch));
      check("state_no_out", {8'h00, st_no}, s[15:0]);
    end
    // Host force, other codes ignored
    force_st(8'h02, 2'h2);
    check("drive_out", {8'h00, drv}, pins(pat[2], nch));
    for (int c = 0; c < 4; c++) begin
      if (c == 2) continue;
      force_st(8'h04, c[1:0]);
      check("drive_out", {8'h00, drv}, pins(pat[2], nch));
      check("state_no_out", {8'h00, st_no}, 16'h0004);
    end
    force_st(8'h04, 2'h2);
    check("drive_out", {8'h00, drv}, pins(pat[4], nch));
    // Three channels in use
    nch <= 4'h3;
    hall(8'h05);
    check("drive_en_out", {8'h00, drv_en}, 16'h0007);
    check("drive_out", {8'h00, drv}, pins(pat[5], 4'h3));
    nch <= 4'h8;
    // Sensorless, match update; window seats at position 100
    force_st(8'h00, 2'h2);
    pos   <= 16'h0064;
    sless <= 1'b1;
    tick(40);
    pos <= 16'h006f;
    await_st(8'h01);
    pos <= 16'h006d;
    await_st(8'h00);
    pos <= 16'h0063;
    await_st(8'h05);
    offs <= 16'h000a;
    await_st(8'h00);
    // Link update: no step without a link, one step with it
    lupd   <= 1'b1;
    period <= 16'hffff;
    tick(20);
    pos <= 16'h0069;
    tick(30);
    check("state_no_out", {8'h00, st_no}, 16'h0000);
    link_pulse();
    await_st(8'h01);
    // Master 13 keeps all eight programmed states, so stepping below zero lands on seven
    master <= 4'hd;
    force_st(8'h00, 2'h2);
    link_pulse();
    tick(2);
    idle();
    pos <= 16'h0068;
    link_pulse();
    await_st(8'h07);
    summarize();
  end
endmodule
`default_nettype wire
